// ---- common/ppfs_pkg.sv ----
`default_nettype none
package ppfs_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_FLASH_CFG = 8'h00;
   localparam logic [7:0] ADDR_OSC_TRIM = 8'h04;
   localparam logic [7:0] ADDR_P3_MODE = 8'h08;
   localparam logic [7:0] ADDR_P3_DATA = 8'h0c;
   localparam logic [7:0] ADDR_P1_LATCH = 8'h10;
   localparam logic [7:0] ADDR_PIN_STATUS = 8'h14;

   // Flash configuration fields
   localparam int CFG_EXT_RST_EN_BIT = 0;
   localparam int CFG_CLK_SRC_LSB = 1;
   localparam int CFG_RTC_XTAL_BIT = 3;
   localparam logic CFG_EXT_RST_EN_RST = 1'h0;
   localparam logic [1:0] CFG_CLK_SRC_RST = 2'h0;
   localparam logic CFG_RTC_XTAL_RST = 1'h0;

   // Oscillator trim fields
   localparam int TRIM_VALUE_W = 6;
   localparam int TRIM_DIVIDED_CLOCK_OUT_EN_BIT = 6;
   localparam logic [5:0] TRIM_VALUE_RST = 6'h00;
   localparam logic TRIM_DIVIDED_CLOCK_OUT_EN_RST = 1'h0;

   // Port 3 fields, two bits of mode per pin
   localparam int P3_PINS = 2;
   localparam int P3_MODE_W = 2;
   localparam logic [3:0] P3_MODE_RST = 4'ha;
   localparam logic [1:0] P3_DATA_RST = 2'h3;

   // Port 1 bit 4 output latch
   localparam int P1_LATCH_BIT = 0;
   localparam logic P1_LATCH_RST = 1'h1;

   // Pin status fields
   localparam int ST_P1_BIT4 = 0;
   localparam int ST_P1_BIT5 = 1;
   localparam int ST_P3_LSB = 2;
   localparam int ST_DIVIDED_CLOCK_OUT = 4;
   localparam int ST_OSC_AMP = 5;
   localparam int ST_OSC_IN = 6;
   localparam int ST_EXT_RST = 7;

   // Execution restart address after reset
   localparam logic [15:0] RESTART_ADDR = 16'h0000;

   typedef enum logic [1:0] {
      CLK_SRC_RC,
      CLK_SRC_WDT,
      CLK_SRC_EXT,
      CLK_SRC_XTAL
   } ppfs_clk_src_type;

   typedef enum logic [1:0] {
      P3_QUASI,
      P3_PUSH_PULL,
      P3_INPUT_ONLY,
      P3_OPEN_DRAIN
   } ppfs_p3_mode_type;
endpackage
`default_nettype wire

// ---- rtl/ppfs_clk_div.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppfs_clk_div (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Control
   input wire logic enable_in,
   // Divided clock
   output logic div_q_out,
   output logic div_nxt_out
);
   logic div_r;
   logic div_nxt;

   // Toggle each edge gives half the CPU clock; parks low when off
   always_comb
   begin
      div_nxt = enable_in ? ~div_r : 1'b0;
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         div_r <= 1'b0;
      end
      else
      begin
         div_r <= div_nxt;
      end
   end

   assign div_q_out = div_r;
   assign div_nxt_out = div_nxt;
endmodule // ppfs_clk_div
`default_nettype wire

// ---- rtl/ppfs_pin_cell.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppfs_pin_cell (
   // Configuration
   input wire logic gpio_en_in,
   input wire logic [1:0] mode_in,
   input wire logic data_in,
   // Pin drive
   output logic out_out,
   output logic oe_out,
   output logic pullup_out
);
   ppfs_pkg::ppfs_p3_mode_type mode;

   always_comb
   begin
      mode = ppfs_pkg::ppfs_p3_mode_type'(mode_in);
      out_out = 1'b0;
      oe_out = 1'b0;
      pullup_out = 1'b0;
      if (gpio_en_in)
      begin
         case (mode)
            ppfs_pkg::P3_QUASI:
            begin
               oe_out = ~data_in;
               pullup_out = 1'b1;
            end
            ppfs_pkg::P3_PUSH_PULL:
            begin
               oe_out = 1'b1;
               out_out = data_in;
            end
            ppfs_pkg::P3_OPEN_DRAIN:
            begin
               oe_out = ~data_in;
            end
            default:
            begin
               oe_out = 1'b0;
            end
         endcase
      end
   end
endmodule // ppfs_pin_cell
`default_nettype wire

// ---- rtl/ppfs_pin_function_select.sv ----
// How it works
// - Low reset pin, when enabled, resets device
// - Port 1 bit 5 is input only
// - Port 3 input only, no pull-up in reset
// - Each port 3 pin configured independently
// - Clock output enable puts CPU clock/2 out
// - Clock output only for RC, watchdog, external
// - Crystal option makes bit 0 amplifier output
// - Bit 1 GPIO only with RC/watchdog clock
// - Port 1 bit 4 feeds second external interrupt
`timescale 1ns/1ps
`default_nettype none
module ppfs_pin_function_select (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // Port 1 upper pins
   input wire logic port1_bit4_pin_in,
   output logic port1_bit4_pin_out,
   output logic port1_bit4_pin_oe_out,
   input wire logic port1_bit5_pin_in,
   // Port 3 pins
   input wire logic [1:0] port3_pin_in,
   output logic [1:0] port3_pin_out,
   output logic [1:0] port3_pin_oe_out,
   output logic [1:0] port3_pullup_out,
   // Oscillator and clock output
   output logic osc_input_out,
   output logic osc_amp_enable_out,
   output logic divided_clock_out,
   // Interrupt and reset
   output logic ext_irq_one_out,
   output logic device_reset_out,
   output logic [15:0] restart_addr_out
);
   logic cfg_ext_rst_en_r;
   logic cfg_ext_rst_en_nxt;
   logic [1:0] cfg_clk_src_r;
   logic [1:0] cfg_clk_src_nxt;
   logic cfg_rtc_xtal_r;
   logic cfg_rtc_xtal_nxt;
   logic [5:0] trim_value_r;
   logic [5:0] trim_value_nxt;
   logic clock_out_enable_r;
   logic clock_out_enable_nxt;
   logic [3:0] p3_mode_r;
   logic [3:0] p3_mode_nxt;
   logic [1:0] p3_data_r;
   logic [1:0] p3_data_nxt;
   logic p1_latch_r;
   logic p1_latch_nxt;
   logic ack_r;
   logic ack_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   logic p1b4_out_r;
   logic p1b4_out_nxt;
   logic p1b4_oe_r;
   logic p1b4_oe_nxt;
   logic [1:0] p3_out_r;
   logic [1:0] p3_out_nxt;
   logic [1:0] p3_oe_r;
   logic [1:0] p3_oe_nxt;
   logic [1:0] p3_pu_r;
   logic [1:0] p3_pu_nxt;
   logic osc_in_r;
   logic osc_in_nxt;
   logic osc_amp_r;
   logic osc_amp_nxt;
   logic irq_r;
   logic irq_nxt;
   logic dev_rst_r;
   logic dev_rst_nxt;
   logic [15:0] restart_r;
   logic [15:0] restart_nxt;

   logic ext_rst;
   logic int_rst;
   logic bus_req;
   logic bus_wr;
   ppfs_pkg::ppfs_clk_src_type clk_src;
   logic osc_amp_sel;
   logic divided_clock_out_ok;
   logic p31_gpio;
   logic [1:0] gpio_en;
   logic [1:0] cell_out;
   logic [1:0] cell_oe;
   logic [1:0] cell_pu;
   logic div_q;
   logic div_nxt;

   // Pin reset only when configured; bit 5 is only ever sampled
   assign ext_rst = cfg_ext_rst_en_r & ~port1_bit5_pin_in;
   assign int_rst = rst_in | ext_rst;
   assign bus_req = wb_cyc_in & wb_stb_in & ~ack_r;
   assign bus_wr = bus_req & wb_we_in & wb_sel_in[0];

   // Pin function selection from configuration
   assign clk_src = ppfs_pkg::ppfs_clk_src_type'(cfg_clk_src_r);
   assign osc_amp_sel = (clk_src == ppfs_pkg::CLK_SRC_XTAL) | cfg_rtc_xtal_r;
   assign divided_clock_out_ok = clock_out_enable_r & ~osc_amp_sel & ~int_rst;
   assign p31_gpio = ((clk_src == ppfs_pkg::CLK_SRC_RC) | (clk_src == ppfs_pkg::CLK_SRC_WDT))
      & ~cfg_rtc_xtal_r;
   assign gpio_en[0] = ~osc_amp_sel & ~divided_clock_out_ok;
   assign gpio_en[1] = p31_gpio;

   // One configuration cell per port 3 pin
   genvar gi;
   generate
      for (gi = 0; gi < ppfs_pkg::P3_PINS; gi++)
      begin : g_p3
         ppfs_pin_cell u_cell (
            .gpio_en_in(gpio_en[gi]),
            .mode_in(p3_mode_r[gi*ppfs_pkg::P3_MODE_W +: ppfs_pkg::P3_MODE_W]),
            .data_in(p3_data_r[gi]),
            .out_out(cell_out[gi]),
            .oe_out(cell_oe[gi]),
            .pullup_out(cell_pu[gi])
         );
      end
   endgenerate

   ppfs_clk_div u_div (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .enable_in(divided_clock_out_ok),
      .div_q_out(div_q),
      .div_nxt_out(div_nxt)
   );

   // Register file and Wishbone answer
   always_comb
   begin
      cfg_ext_rst_en_nxt = cfg_ext_rst_en_r;
      cfg_clk_src_nxt = cfg_clk_src_r;
      cfg_rtc_xtal_nxt = cfg_rtc_xtal_r;
      trim_value_nxt = trim_value_r;
      clock_out_enable_nxt = clock_out_enable_r;
      p3_mode_nxt = p3_mode_r;
      p3_data_nxt = p3_data_r;
      p1_latch_nxt = p1_latch_r;
      ack_nxt = bus_req;
      rdata_nxt = 32'h0000_0000;
      if (bus_wr)
      begin
         case (wb_adr_in)
            ppfs_pkg::ADDR_FLASH_CFG:
            begin
               cfg_ext_rst_en_nxt = wb_dat_in[ppfs_pkg::CFG_EXT_RST_EN_BIT];
               cfg_clk_src_nxt = wb_dat_in[ppfs_pkg::CFG_CLK_SRC_LSB +: 2];
               cfg_rtc_xtal_nxt = wb_dat_in[ppfs_pkg::CFG_RTC_XTAL_BIT];
            end
            ppfs_pkg::ADDR_OSC_TRIM:
            begin
               trim_value_nxt = wb_dat_in[ppfs_pkg::TRIM_VALUE_W-1:0];
               clock_out_enable_nxt = wb_dat_in[ppfs_pkg::TRIM_DIVIDED_CLOCK_OUT_EN_BIT];
            end
            ppfs_pkg::ADDR_P3_MODE:
            begin
               p3_mode_nxt = wb_dat_in[3:0];
            end
            ppfs_pkg::ADDR_P3_DATA:
            begin
               p3_data_nxt = wb_dat_in[1:0];
            end
            ppfs_pkg::ADDR_P1_LATCH:
            begin
               p1_latch_nxt = wb_dat_in[ppfs_pkg::P1_LATCH_BIT];
            end
            default:
            begin
            end
         endcase
      end
      if (bus_req && !wb_we_in)
      begin
         case (wb_adr_in)
            ppfs_pkg::ADDR_FLASH_CFG:
            begin
               rdata_nxt[3:0] = {cfg_rtc_xtal_r, cfg_clk_src_r, cfg_ext_rst_en_r};
            end
            ppfs_pkg::ADDR_OSC_TRIM:
            begin
               rdata_nxt[6:0] = {clock_out_enable_r, trim_value_r};
            end
            ppfs_pkg::ADDR_P3_MODE:
            begin
               rdata_nxt[3:0] = p3_mode_r;
            end
            ppfs_pkg::ADDR_P3_DATA:
            begin
               rdata_nxt[1:0] = p3_data_r;
            end
            ppfs_pkg::ADDR_P1_LATCH:
            begin
               rdata_nxt[ppfs_pkg::P1_LATCH_BIT] = p1_latch_r;
            end
            ppfs_pkg::ADDR_PIN_STATUS:
            begin
               rdata_nxt[ppfs_pkg::ST_P1_BIT4] = port1_bit4_pin_in;
               rdata_nxt[ppfs_pkg::ST_P1_BIT5] = port1_bit5_pin_in;
               rdata_nxt[ppfs_pkg::ST_P3_LSB +: 2] = port3_pin_in;
               rdata_nxt[ppfs_pkg::ST_DIVIDED_CLOCK_OUT] = divided_clock_out_ok;
               rdata_nxt[ppfs_pkg::ST_OSC_AMP] = osc_amp_sel;
               rdata_nxt[ppfs_pkg::ST_OSC_IN] = ~p31_gpio;
               rdata_nxt[ppfs_pkg::ST_EXT_RST] = ext_rst;
            end
            default:
            begin
               rdata_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   // Flash configuration survives pin reset; trim and port state return to defaults
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         cfg_ext_rst_en_r <= ppfs_pkg::CFG_EXT_RST_EN_RST;
         cfg_clk_src_r <= ppfs_pkg::CFG_CLK_SRC_RST;
         cfg_rtc_xtal_r <= ppfs_pkg::CFG_RTC_XTAL_RST;
         ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end
      else
      begin
         cfg_ext_rst_en_r <= cfg_ext_rst_en_nxt;
         cfg_clk_src_r <= cfg_clk_src_nxt;
         cfg_rtc_xtal_r <= cfg_rtc_xtal_nxt;
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
      if (int_rst)
      begin
         trim_value_r <= ppfs_pkg::TRIM_VALUE_RST;
         clock_out_enable_r <= ppfs_pkg::TRIM_DIVIDED_CLOCK_OUT_EN_RST;
         p3_mode_r <= ppfs_pkg::P3_MODE_RST;
         p3_data_r <= ppfs_pkg::P3_DATA_RST;
         p1_latch_r <= ppfs_pkg::P1_LATCH_RST;
      end
      else
      begin
         trim_value_r <= trim_value_nxt;
         clock_out_enable_r <= clock_out_enable_nxt;
         p3_mode_r <= p3_mode_nxt;
         p3_data_r <= p3_data_nxt;
         p1_latch_r <= p1_latch_nxt;
      end
   end

   // Pin drive next values
   always_comb
   begin
      irq_nxt = port1_bit4_pin_in;
      dev_rst_nxt = int_rst;
      restart_nxt = ppfs_pkg::RESTART_ADDR;
      p1b4_out_nxt = 1'b0;
      p1b4_oe_nxt = 1'b0;
      p3_out_nxt = 2'h0;
      p3_oe_nxt = 2'h0;
      p3_pu_nxt = 2'h0;
      osc_in_nxt = 1'b0;
      osc_amp_nxt = 1'b0;
      if (!int_rst)
      begin
         p1b4_oe_nxt = ~p1_latch_r;
         p3_out_nxt[1] = cell_out[1];
         p3_oe_nxt[1] = cell_oe[1];
         p3_pu_nxt = cell_pu;
         osc_amp_nxt = osc_amp_sel;
         osc_in_nxt = p31_gpio ? 1'b0 : port3_pin_in[1];
         if (divided_clock_out_ok)
         begin
            p3_out_nxt[0] = div_nxt;
            p3_oe_nxt[0] = 1'b1;
         end
         else
         begin
            p3_out_nxt[0] = cell_out[0];
            p3_oe_nxt[0] = cell_oe[0];
         end
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         irq_r <= 1'b0;
         dev_rst_r <= 1'b1;
         restart_r <= ppfs_pkg::RESTART_ADDR;
         p1b4_out_r <= 1'b0;
         p1b4_oe_r <= 1'b0;
         p3_out_r <= 2'h0;
         p3_oe_r <= 2'h0;
         p3_pu_r <= 2'h0;
         osc_in_r <= 1'b0;
         osc_amp_r <= 1'b0;
      end
      else
      begin
         irq_r <= irq_nxt;
         dev_rst_r <= dev_rst_nxt;
         restart_r <= restart_nxt;
         p1b4_out_r <= p1b4_out_nxt;
         p1b4_oe_r <= p1b4_oe_nxt;
         p3_out_r <= p3_out_nxt;
         p3_oe_r <= p3_oe_nxt;
         p3_pu_r <= p3_pu_nxt;
         osc_in_r <= osc_in_nxt;
         osc_amp_r <= osc_amp_nxt;
      end
   end

   assign wb_ack_out = ack_r;
   assign wb_dat_out = rdata_r;
   assign port1_bit4_pin_out = p1b4_out_r;
   assign port1_bit4_pin_oe_out = p1b4_oe_r;
   assign port3_pin_out = p3_out_r;
   assign port3_pin_oe_out = p3_oe_r;
   assign port3_pullup_out = p3_pu_r;
   assign osc_input_out = osc_in_r;
   assign osc_amp_enable_out = osc_amp_r;
   assign divided_clock_out = div_q;
   assign ext_irq_one_out = irq_r;
   assign device_reset_out = dev_rst_r;
   assign restart_addr_out = restart_r;

   // Checks
   a_ack_single: assert property (@(posedge core_clk_in) disable iff (rst_in)
      wb_ack_out |=> !wb_ack_out)
      else $error("ack held longer than one cycle");
   a_ack_follows_req: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
      else $error("request not answered in one cycle");
   a_pin_reset: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (cfg_ext_rst_en_r && !port1_bit5_pin_in) |=> device_reset_out && restart_addr_out == 16'h0000)
      else $error("low reset pin did not reset device");
   a_p3_reset_input: assert property (@(posedge core_clk_in)
      int_rst |=> (port3_pin_oe_out == 2'h0) && (port3_pullup_out == 2'h0))
      else $error("port 3 driven or pulled up during reset");
   a_divided_clock_out_toggles: assert property (@(posedge core_clk_in) disable iff (rst_in)
      divided_clock_out_ok |=> (divided_clock_out != $past(divided_clock_out)) && port3_pin_oe_out[0]
         && (port3_pin_out[0] == divided_clock_out))
      else $error("clock output not half rate on port 3 bit 0");
   a_divided_clock_out_blocked: assert property (@(posedge core_clk_in) disable iff (rst_in)
      osc_amp_sel |=> !divided_clock_out)
      else $error("clock output active with crystal pins in use");
   a_xtal_amp: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (osc_amp_sel && !int_rst) |=> osc_amp_enable_out && !port3_pin_oe_out[0])
      else $error("port 3 bit 0 not released to amplifier");
   a_osc_input: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (!p31_gpio && !int_rst) |=> !port3_pin_oe_out[1] && (osc_input_out == $past(port3_pin_in[1])))
      else $error("port 3 bit 1 not serving as oscillator input");
   a_irq_follow: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> ext_irq_one_out == $past(port1_bit4_pin_in))
      else $error("interrupt input does not follow port 1 bit 4");
   a_pin1_indep: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (p31_gpio && !int_rst && p3_mode_r[3:2] == 2'h1) |=> port3_pin_oe_out[1]
         && port3_pin_out[1] == $past(p3_data_r[1]))
      else $error("port 3 bit 1 ignores its own mode");
endmodule // ppfs_pin_function_select
`default_nettype wire

// ---- rtl/ppfs_placeholder_none.sv ----
`default_nettype none
`default_nettype wire

// ---- verification/ppfs_board_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppfs_board_model (
   // Clock
   input wire logic core_clk_in,
   // Bench controls
   input wire logic press_reset_in,
   input wire logic p14_low_in,
   input wire logic [1:0] p3_drv_en_in,
   input wire logic [1:0] p3_drv_val_in,
   // Device pin drive
   input wire logic p14_out_in,
   input wire logic p14_oe_in,
   input wire logic [1:0] p3_out_in,
   input wire logic [1:0] p3_oe_in,
   input wire logic [1:0] p3_pullup_in,
   // Resolved pin levels
   output logic p15_level_out,
   output logic p14_level_out,
   output logic [1:0] p3_level_out
);
   logic float_r;
   initial float_r = 1'h0;
   // Undriven line without pull-up wanders
   always @(posedge core_clk_in)
      float_r <= ~float_r;
   // Reset button with board pull-up
   assign p15_level_out = press_reset_in ? 1'h0 : 1'h1;
   assign p14_level_out = p14_oe_in ? p14_out_in : !p14_low_in;
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         p3_level_out[i] = p3_oe_in[i] ? p3_out_in[i] : p3_drv_en_in[i] ? p3_drv_val_in[i] :
            p3_pullup_in[i] ? 1'h1 : float_r;
      end
   end
endmodule // ppfs_board_model
`default_nettype wire

// ---- verification/ppfs_pin_function_select_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppfs_pin_function_select_bench;
   logic clk, rst, cyc, stb, we, ack, p14_o, p14_oe, osc_in_o, amp_en, div_clk, irq_one, dev_rst;
   logic press, p14_low, p15_lvl, p14_lvl, a, b, amp_exp, osc_exp;
   logic [7:0] adr, cfg;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, dat_o;
   logic [1:0] p3_o, p3_oe, p3_pu, p3_lvl, p3_en, p3_val;
   logic [15:0] restart;
   int err_count, checked;

   initial clk = 1'h0;
   always #5 clk = ~clk;

   ppfs_pin_function_select dut (.core_clk_in(clk), .rst_in(rst), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
      .wb_dat_out(dat_o), .wb_ack_out(ack), .port1_bit4_pin_in(p14_lvl),
      .port1_bit4_pin_out(p14_o), .port1_bit4_pin_oe_out(p14_oe), .port1_bit5_pin_in(p15_lvl),
      .port3_pin_in(p3_lvl), .port3_pin_out(p3_o), .port3_pin_oe_out(p3_oe),
      .port3_pullup_out(p3_pu), .osc_input_out(osc_in_o), .osc_amp_enable_out(amp_en),
      .divided_clock_out(div_clk), .ext_irq_one_out(irq_one), .device_reset_out(dev_rst),
      .restart_addr_out(restart));

   ppfs_board_model board (.core_clk_in(clk), .press_reset_in(press), .p14_low_in(p14_low),
      .p3_drv_en_in(p3_en), .p3_drv_val_in(p3_val), .p14_out_in(p14_o), .p14_oe_in(p14_oe),
      .p3_out_in(p3_o), .p3_oe_in(p3_oe), .p3_pullup_in(p3_pu), .p15_level_out(p15_lvl),
      .p14_level_out(p14_lvl), .p3_level_out(p3_lvl));

   task results;
      if (err_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task wb_cycle(input logic w, input logic [7:0] addr, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= addr;
      wdat <= d;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'h1 && n < 50);
      if (ack !== 1'h1)
      begin
         err_count++;
         $display("mismatch at %0t: no bus answer", $time);
         results();
      end
      else
      begin
         rdat = dat_o;
         cyc <= 1'h0;
         stb <= 1'h0;
         we <= 1'h0;
      end
   endtask

   task wr(input logic [7:0] addr, input logic [31:0] d);
      wb_cycle(1'h1, addr, d);
   endtask

   task rd(input logic [7:0] addr, input logic [31:0] exp);
      wb_cycle(1'h0, addr, 32'h0);
      check(rdat, exp);
   endtask

   task settle;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // Two samples of the divided clock: toggling when live, low when off
   task check_div(input logic exp);
      a = div_clk;
      @(posedge clk);
      #1;
      b = div_clk;
      check({a ^ b, a | b}, {exp, exp});
   endtask

   initial
   begin
      {cyc, stb, we, press, p14_low} = 5'h0;
      {adr, wdat, p3_en, p3_val} = 44'h0;
      sel = 4'hf;
      rst = 1'h1;
      err_count = 0;
      checked = 0;
      repeat (4) @(posedge clk);
      #1;
      check({dev_rst, p3_oe, p3_pu}, 5'h10);
      @(posedge clk);
      rst <= 1'h0;
      rd(ppfs_pkg::ADDR_FLASH_CFG, 32'h0);
      rd(ppfs_pkg::ADDR_OSC_TRIM, 32'h0);
      rd(ppfs_pkg::ADDR_P3_MODE, {28'h0, ppfs_pkg::P3_MODE_RST});
      rd(ppfs_pkg::ADDR_P3_DATA, {30'h0, ppfs_pkg::P3_DATA_RST});
      rd(ppfs_pkg::ADDR_P1_LATCH, 32'h1);
      wr(8'h18, 32'hff);
      rd(8'h18, 32'h0);
      // Pin 0 push-pull, pin 1 input only and driven by the board
      wr(ppfs_pkg::ADDR_P3_MODE, 32'h9);
      wr(ppfs_pkg::ADDR_P3_DATA, 32'h0);
      @(posedge clk);
      p3_en <= 2'h2;
      p3_val <= 2'h2;
      settle();
      check({p3_oe, p3_o}, 4'h4);
      rd(ppfs_pkg::ADDR_PIN_STATUS, 32'hb);
      check(rdat[3:2], 2'h2);
      wr(ppfs_pkg::ADDR_P3_DATA, 32'h1);
      settle();
      check({p3_oe, p3_o}, 4'h5);
      wr(ppfs_pkg::ADDR_P3_MODE, 32'h8);
      settle();
      check({p3_oe[0], p3_pu}, 3'h1);
      // Pin 0 open-drain pulling low
      wr(ppfs_pkg::ADDR_P3_MODE, 32'hb);
      wr(ppfs_pkg::ADDR_P3_DATA, 32'h0);
      settle();
      check({p3_oe[0], p3_o[0], p3_pu}, 4'h8);
      // Clock source sweep with clock output enabled, pin 1 held high
      wr(ppfs_pkg::ADDR_P3_MODE, 32'ha);
      wr(ppfs_pkg::ADDR_OSC_TRIM, 32'h40);
      for (int k = 0; k < 8; k++)
      begin
         cfg = {4'h0, k[2], k[1:0], 1'h0};
         amp_exp = (k[1:0] == 2'h3) || k[2];
         osc_exp = !(k[1:0] <= 2'h1 && !k[2]);
         wr(ppfs_pkg::ADDR_FLASH_CFG, {24'h0, cfg});
         settle();
         check(amp_en, amp_exp);
         check(osc_in_o, osc_exp);
         check_div(!amp_exp);
      end
      wr(ppfs_pkg::ADDR_FLASH_CFG, 32'h0);
      wr(ppfs_pkg::ADDR_OSC_TRIM, 32'h0);
      settle();
      check_div(1'h0);
      // Interrupt input follows port 1 bit 4
      @(posedge clk);
      p3_en <= 2'h3;
      p3_val <= 2'h0;
      p14_low <= 1'h1;
      settle();
      check(irq_one, 1'h0);
      @(posedge clk);
      p14_low <= 1'h0;
      settle();
      check(irq_one, 1'h1);
      wr(ppfs_pkg::ADDR_P1_LATCH, 32'h0);
      settle();
      check({p14_o, p14_oe, irq_one}, 3'h2);
      // Pin reset ignored while disabled, then resets device once enabled
      @(posedge clk);
      press <= 1'h1;
      settle();
      check(dev_rst, 1'h0);
      rd(ppfs_pkg::ADDR_PIN_STATUS, 32'h0);
      check(rdat[1], 1'h0);
      @(posedge clk);
      press <= 1'h0;
      wr(ppfs_pkg::ADDR_FLASH_CFG, 32'h1);
      wr(ppfs_pkg::ADDR_OSC_TRIM, 32'h40);
      wr(ppfs_pkg::ADDR_P3_MODE, 32'h5);
      settle();
      check(p3_oe, 2'h3);
      @(posedge clk);
      press <= 1'h1;
      settle();
      check({dev_rst, restart, p3_oe, p3_pu}, {1'h1, 16'h0, 4'h0});
      check_div(1'h0);
      @(posedge clk);
      press <= 1'h0;
      settle();
      check(dev_rst, 1'h0);
      rd(ppfs_pkg::ADDR_OSC_TRIM, 32'h0);
      rd(ppfs_pkg::ADDR_P3_MODE, 32'ha);
      rd(ppfs_pkg::ADDR_P1_LATCH, 32'h1);
      rd(ppfs_pkg::ADDR_FLASH_CFG, 32'h1);
      results();
   end
endmodule // ppfs_pin_function_select_bench
`default_nettype wire
